// >>> hw/key_panel.v
// Added by the designer: the strobed register port and the placing of the registers.
`timescale 1ns/1ns
`include "key_panel_regs.vh"
// Behaviour
// - Key one alone released within 5 to 10 s starts automatic teach.
// - Key one alone released after over 10 s starts manual teach.
// - Brief key two press toggles pilot valve, only in hand state.
// - Key two alone released within 10 to 30 s toggles inversion.
// - Both keys released within 2 to 10 s toggle hand and auto.
// - Both keys released after over 10 s, up to 30 s, request a restart.
// - Both keys released after over 30 s request factory reset.
// - Pilot indicator lit steadily while the pilot valve is on, unless flashing.
// - Manual indicator lit in hand state unless key flashing overrides.
// - Both keys held: manual flashes 5 Hz to 2 s, 10 Hz to 10 s.
// - Inversion indicator lit while inversion active, unless flashing.
// - Key two held: inversion flashes 5 Hz to 10 s, then 10 Hz.
// - Key one held: manual and inversion flash 5, 10, then 5 Hz.
// - Both past 10 s: three indicators 5 Hz to 30 s, then 10 Hz.
// - Each hold window boundary changes the flash rate shown, except key two at 30 s.
// - Key presses begun while the local control lock is set are ignored.
// - Hand state flashes status orange unless mode is off; auto state shows the selected mode.
// - Bus pair: off/off no power, on/on watchdog, on/off normal.
// - Bus pair: flash/on addr zero, on/flash overload, both flash error.
// - Status indicator has six display modes, valve plus warnings default.
module key_panel #(
  parameter CLK_HZ = `CLK_HZ,
  parameter MS_CYCLES = CLK_HZ / 1000,
  parameter DEBOUNCE_MS = `DEBOUNCE_MS
) (
  input wire sys_clk,
  input wire reset,
  input wire key_one,
  input wire key_two,
  input wire [7:0] addr,
  input wire [31:0] wdata,
  input wire wr_en,
  input wire rd_en,
  output reg [31:0] rdata,
  input wire valve_open,
  input wire valve_closed,
  input wire device_error,
  input wire function_check,
  input wire out_of_spec,
  input wire maint_required,
  output reg auto_teach_start,
  output reg manual_teach_start,
  output reg restart_req,
  output reg factory_reset_req,
  output wire pilot_valve,
  output reg pilot_indicator,
  output reg manual_indicator,
  output reg direction_inversion_indicator,
  output reg [2:0] status_rgb,
  output reg bus_power_indicator,
  output reg bus_fault_indicator
);
  localparam SLOW_HALF = CLK_HZ / (2 * `SLOW_HZ);
  localparam FAST_HALF = CLK_HZ / (2 * `FAST_HZ);
  // One-hot hold states
  localparam ST_IDLE = 4'b0001;
  localparam ST_ONE = 4'b0010;
  localparam ST_TWO = 4'b0100;
  localparam ST_BOTH = 4'b1000;
  // RGB colours for the status indicator
  localparam RGB_OFF = 3'h0;
  localparam RGB_RED = 3'h4;
  localparam RGB_GREEN = 3'h2;
  localparam RGB_BLUE = 3'h1;
  localparam RGB_YELLOW = 3'h6;
  localparam RGB_ORANGE = 3'h5;
  localparam RGB_WHITE = 3'h7;

  reg k1_meta_reg, k1_sync_reg, k2_meta_reg, k2_sync_reg;
  reg k1_deb_reg, k2_deb_reg;
  reg [15:0] deb1_cnt_reg, deb2_cnt_reg;
  reg [15:0] ms_cnt_reg;
  reg ms_tick;
  reg [15:0] hold_ms_reg;
  reg [3:0] state_reg;
  reg [3:0] ctrl_reg;
  reg [2:0] mode_reg;
  reg [2:0] bus_reg;
  reg [23:0] slow_cnt_reg, fast_cnt_reg;
  reg slow_reg, fast_reg;
  wire lock = ctrl_reg[`CTRL_LOCK_BIT];
  wire hand_operating_state = ctrl_reg[`CTRL_HAND_BIT];
  wire inversion = ctrl_reg[`CTRL_INV_BIT];
  assign pilot_valve = ctrl_reg[`CTRL_PILOT_BIT];

  // Two-stage synchronisers; the first stage feeds only the second
  always @(posedge sys_clk or posedge reset) begin
    if (reset) begin
      k1_meta_reg <= 1'b0;
      k1_sync_reg <= 1'b0;
      k2_meta_reg <= 1'b0;
      k2_sync_reg <= 1'b0;
    end else begin
      k1_meta_reg <= key_one;
      k1_sync_reg <= k1_meta_reg;
      k2_meta_reg <= key_two;
      k2_sync_reg <= k2_meta_reg;
    end
  end

  // Millisecond tick, shared by debounce and hold timing
  always @(posedge sys_clk or posedge reset) begin
    if (reset) begin
      ms_cnt_reg <= 16'h0000;
      ms_tick <= 1'b0;
    end else if (ms_cnt_reg == MS_CYCLES[15:0] - 16'h0001) begin
      ms_cnt_reg <= 16'h0000;
      ms_tick <= 1'b1;
    end else begin
      ms_cnt_reg <= ms_cnt_reg + 16'h0001;
      ms_tick <= 1'b0;
    end
  end

  // Debounce: a level must differ for DEBOUNCE_MS ticks to be accepted
  always @(posedge sys_clk or posedge reset) begin
    if (reset) begin
      deb1_cnt_reg <= 16'h0000;
      deb2_cnt_reg <= 16'h0000;
      k1_deb_reg <= 1'b0;
      k2_deb_reg <= 1'b0;
    end else begin
      if (k1_sync_reg == k1_deb_reg) begin
        deb1_cnt_reg <= 16'h0000;
      end else if (ms_tick) begin
        if (deb1_cnt_reg == DEBOUNCE_MS[15:0] - 16'h0001) begin
          k1_deb_reg <= k1_sync_reg;
          deb1_cnt_reg <= 16'h0000;
        end else begin
          deb1_cnt_reg <= deb1_cnt_reg + 16'h0001;
        end
      end
      if (k2_sync_reg == k2_deb_reg) begin
        deb2_cnt_reg <= 16'h0000;
      end else if (ms_tick) begin
        if (deb2_cnt_reg == DEBOUNCE_MS[15:0] - 16'h0001) begin
          k2_deb_reg <= k2_sync_reg;
          deb2_cnt_reg <= 16'h0000;
        end else begin
          deb2_cnt_reg <= deb2_cnt_reg + 16'h0001;
        end
      end
    end
  end

  // Flash rate enables; square waves at 5 Hz and 10 Hz
  always @(posedge sys_clk or posedge reset) begin
    if (reset) begin
      slow_cnt_reg <= 24'h000000;
      fast_cnt_reg <= 24'h000000;
      slow_reg <= 1'b0;
      fast_reg <= 1'b0;
    end else begin
      if (slow_cnt_reg == SLOW_HALF[23:0] - 24'h000001) begin
        slow_cnt_reg <= 24'h000000;
        slow_reg <= ~slow_reg;
      end else begin
        slow_cnt_reg <= slow_cnt_reg + 24'h000001;
      end
      if (fast_cnt_reg == FAST_HALF[23:0] - 24'h000001) begin
        fast_cnt_reg <= 24'h000000;
        fast_reg <= ~fast_reg;
      end else begin
        fast_cnt_reg <= fast_cnt_reg + 24'h000001;
      end
    end
  end

  wire any_key = k1_deb_reg | k2_deb_reg;
  wire [3:0] combo = (k1_deb_reg & k2_deb_reg) ? ST_BOTH :
                     k1_deb_reg ? ST_ONE : k2_deb_reg ? ST_TWO : ST_IDLE;
  // Hold windows; the ge compares include the boundary, the gt compares exclude it
  wire ge2 = hold_ms_reg >= `T_2S_MS;
  wire ge5 = hold_ms_reg >= `T_5S_MS;
  wire ge10 = hold_ms_reg >= `T_10S_MS;
  wire gt10 = hold_ms_reg > `T_10S_MS;
  wire ge30 = hold_ms_reg >= `T_30S_MS;
  wire gt30 = hold_ms_reg > `T_30S_MS;
  // Releasing the last key ends the combination
  wire release_evt = (state_reg != ST_IDLE) && !any_key;

  // Hold timer and combination tracker. Once both keys were seen the
  // combination stays "both" until all keys are up, so releasing the
  // two keys a few ms apart does not fall back to a single-key action.
  always @(posedge sys_clk or posedge reset) begin
    if (reset) begin
      state_reg <= ST_IDLE;
      hold_ms_reg <= 16'h0000;
    end else begin
      case (state_reg)
        ST_IDLE: begin
          hold_ms_reg <= 16'h0000;
          if (any_key && !lock) begin
            state_reg <= combo;
          end
        end
        ST_ONE, ST_TWO: begin
          if (!any_key) begin
            state_reg <= ST_IDLE;
          end else if (combo == ST_BOTH) begin
            state_reg <= ST_BOTH;
            hold_ms_reg <= 16'h0000;
          end else if (ms_tick && hold_ms_reg != 16'hffff) begin
            hold_ms_reg <= hold_ms_reg + 16'h0001;
          end
        end
        ST_BOTH: begin
          if (!any_key) begin
            state_reg <= ST_IDLE;
          end else if (ms_tick && hold_ms_reg != 16'hffff) begin
            hold_ms_reg <= hold_ms_reg + 16'h0001;
          end
        end
        default: begin
          state_reg <= ST_IDLE;
        end
      endcase
    end
  end

  // Action decode on release; pulses last one cycle
  wire act_auto = release_evt && state_reg == ST_ONE && ge5 && !gt10;
  wire act_manual = release_evt && state_reg == ST_ONE && gt10;
  wire act_pilot = release_evt && state_reg == ST_TWO && !ge10 &&
                   hand_operating_state;
  wire act_inv = release_evt && state_reg == ST_TWO && ge10 && !gt30;
  wire act_hand = release_evt && state_reg == ST_BOTH && ge2 && !gt10;
  wire act_restart = release_evt && state_reg == ST_BOTH && gt10 && !gt30;
  wire act_factory = release_evt && state_reg == ST_BOTH && gt30;

  always @(posedge sys_clk or posedge reset) begin
    if (reset) begin
      auto_teach_start <= 1'b0;
      manual_teach_start <= 1'b0;
      restart_req <= 1'b0;
      factory_reset_req <= 1'b0;
    end else begin
      auto_teach_start <= act_auto;
      manual_teach_start <= act_manual;
      restart_req <= act_restart;
      factory_reset_req <= act_factory;
    end
  end

  // Register file; a key action in the same cycle as a software write toggles the written bit
  always @(posedge sys_clk or posedge reset) begin
    if (reset) begin
      ctrl_reg <= `CTRL_RESET;
      mode_reg <= `MODE_RESET;
      bus_reg <= `BUS_RESET;
    end else begin
      if (wr_en && addr == `CTRL_OFFSET) begin
        ctrl_reg <= wdata[3:0];
      end else begin
        if (act_pilot) begin
          ctrl_reg[`CTRL_PILOT_BIT] <= ~pilot_valve;
        end
        if (act_inv) begin
          ctrl_reg[`CTRL_INV_BIT] <= ~inversion;
        end
        if (act_hand) begin
          ctrl_reg[`CTRL_HAND_BIT] <= ~hand_operating_state;
        end
      end
      if (wr_en && addr == `CTRL_OFFSET && (act_pilot | act_inv | act_hand))
      begin
        ctrl_reg <= wdata[3:0] ^ {act_pilot, act_inv, act_hand, 1'b0};
      end
      // New mode is stored at once and drives the status indicator from the next cycle
      if (wr_en && addr == `MODE_OFFSET && wdata[2:0] <= `MODE_OFF) begin
        mode_reg <= wdata[2:0];
      end
      if (wr_en && addr == `BUS_OFFSET && wdata[2:0] <= `BUS_PERIPH_ERR) begin
        bus_reg <= wdata[2:0];
      end
    end
  end

  // Read data in the cycle after the strobe; unmapped reads zero
  always @(posedge sys_clk or posedge reset) begin
    if (reset) begin
      rdata <= 32'h00000000;
    end else if (rd_en) begin
      case (addr)
        `CTRL_OFFSET: rdata <= {28'h0000000, ctrl_reg};
        `STATUS_OFFSET: rdata <= {12'h000, hold_ms_reg, state_reg};
        `MODE_OFFSET: rdata <= {29'h00000000, mode_reg};
        `BUS_OFFSET: rdata <= {29'h00000000, bus_reg};
        default: rdata <= 32'h00000000;
      endcase
    end else begin
      rdata <= 32'h00000000;
    end
  end

  // Small indicators; the flash pattern encodes the current window
  always @(posedge sys_clk or posedge reset) begin
    if (reset) begin
      pilot_indicator <= 1'b0;
      manual_indicator <= 1'b0;
      direction_inversion_indicator <= 1'b0;
    end else begin
      pilot_indicator <= pilot_valve;
      manual_indicator <= hand_operating_state;
      direction_inversion_indicator <= inversion;
      case (state_reg)
        ST_ONE: begin
          manual_indicator <= (ge5 && !gt10) ? fast_reg : slow_reg;
          direction_inversion_indicator <= (ge5 && !gt10) ? fast_reg :
                                           slow_reg;
        end
        ST_TWO: begin
          direction_inversion_indicator <= ge10 ? fast_reg : slow_reg;
        end
        ST_BOTH: begin
          if (gt10) begin
            pilot_indicator <= gt30 ? fast_reg : slow_reg;
            manual_indicator <= gt30 ? fast_reg : slow_reg;
            direction_inversion_indicator <= gt30 ? fast_reg : slow_reg;
          end else begin
            manual_indicator <= ge2 ? fast_reg : slow_reg;
          end
        end
        default: begin
        end
      endcase
    end
  end

  // Status indicator; in the valve-error and valve-warning modes errors alternate with the valve colour at 5 Hz
  reg [2:0] valve_rgb;
  reg [2:0] status_colour;
  always @* begin
    valve_rgb = valve_open ? RGB_YELLOW : valve_closed ? RGB_GREEN : RGB_OFF;
    status_colour = device_error ? RGB_RED : function_check ? RGB_ORANGE :
                    out_of_spec ? RGB_YELLOW :
                    maint_required ? RGB_BLUE : RGB_GREEN;
  end

  always @(posedge sys_clk or posedge reset) begin
    if (reset) begin
      status_rgb <= RGB_OFF;
    end else begin
      case (mode_reg)
        `MODE_VALVE: status_rgb <= valve_rgb;
        `MODE_VALVE_ERR: status_rgb <= (device_error && slow_reg) ? RGB_RED :
                                      valve_rgb;
        `MODE_VALVE_WARN: status_rgb <= (status_colour != RGB_GREEN &&
                                        slow_reg) ? status_colour : valve_rgb;
        `MODE_NAMUR: status_rgb <= status_colour;
        `MODE_FIXED: status_rgb <= RGB_WHITE;
        default: status_rgb <= RGB_OFF;
      endcase
      // Hand state overrides the display with orange flashing, except in MODE_OFF
      if (hand_operating_state && mode_reg != `MODE_OFF) begin
        status_rgb <= slow_reg ? RGB_ORANGE : RGB_OFF;
      end
    end
  end

  // Bus power and fault pair
  always @(posedge sys_clk or posedge reset) begin
    if (reset) begin
      bus_power_indicator <= 1'b0;
      bus_fault_indicator <= 1'b0;
    end else begin
      case (bus_reg)
        `BUS_OK: begin
          bus_power_indicator <= 1'b1;
          bus_fault_indicator <= 1'b0;
        end
        `BUS_WATCHDOG: begin
          bus_power_indicator <= 1'b1;
          bus_fault_indicator <= 1'b1;
        end
        `BUS_ADDR_ZERO: begin
          bus_power_indicator <= slow_reg;
          bus_fault_indicator <= 1'b1;
        end
        `BUS_OVERLOAD: begin
          bus_power_indicator <= 1'b1;
          bus_fault_indicator <= slow_reg;
        end
        `BUS_PERIPH_ERR: begin
          bus_power_indicator <= slow_reg;
          bus_fault_indicator <= slow_reg;
        end
        default: begin
          bus_power_indicator <= 1'b0;
          bus_fault_indicator <= 1'b0;
        end
      endcase
    end
  end
endmodule

// >>> hw/key_panel_regs.vh
`ifndef KEY_PANEL_REGS_VH
`define KEY_PANEL_REGS_VH

// Register offsets (byte addresses, one 32-bit register every 4 bytes)
`define CTRL_OFFSET 8'h00
`define STATUS_OFFSET 8'h04
`define MODE_OFFSET 8'h08
`define BUS_OFFSET 8'h0c

// Control register fields
`define CTRL_LOCK_BIT 0
`define CTRL_HAND_BIT 1
`define CTRL_INV_BIT 2
`define CTRL_PILOT_BIT 3

// Reset values
`define CTRL_RESET 4'h0
`define MODE_RESET 3'h2
`define BUS_RESET 3'h0

// Status indicator display modes
`define MODE_VALVE 3'h0
`define MODE_VALVE_ERR 3'h1
`define MODE_VALVE_WARN 3'h2
`define MODE_NAMUR 3'h3
`define MODE_FIXED 3'h4
`define MODE_OFF 3'h5

// Bus state codes
`define BUS_NO_POWER 3'h0
`define BUS_OK 3'h1
`define BUS_WATCHDOG 3'h2
`define BUS_ADDR_ZERO 3'h3
`define BUS_OVERLOAD 3'h4
`define BUS_PERIPH_ERR 3'h5

// Timing, in milliseconds and hertz
`define CLK_HZ 50000000
`define T_2S_MS 2000
`define T_5S_MS 5000
`define T_10S_MS 10000
`define T_30S_MS 30000
`define DEBOUNCE_MS 20
`define SLOW_HZ 5
`define FAST_HZ 10

`endif

// >>> verification/key_operator.sv
`timescale 1ns/1ns
// Operator at the two keys; contacts chatter when closing
module key_operator #(
  parameter MS_CYCLES = 1
) (
  input wire sys_clk,
  output logic key_one,
  output logic key_two
);
  initial key_one = 1'b0;
  initial key_two = 1'b0;

  // Press keys in m for ms, chattering first, then let go cleanly
  task hold(input [1:0] m, input int ms);
    int i;
    for (i = 0; i < 5; i++) begin
      @(posedge sys_clk);
      {key_two, key_one} <= i[0] ? 2'b00 : m;
    end
    repeat (ms * MS_CYCLES) @(posedge sys_clk);
    {key_two, key_one} <= 2'b00;
  endtask
endmodule

// >>> verification/key_panel_properties.sv
`timescale 1ns/1ns
// Ties action pulses and indicators to the raw key activity
module key_panel_properties #(
  parameter MS_CYCLES = 1
) (
  input wire sys_clk,
  input wire reset,
  input wire key_one,
  input wire key_two,
  input wire wr_en,
  input wire auto_teach_start,
  input wire manual_teach_start,
  input wire restart_req,
  input wire factory_reset_req,
  input wire pilot_valve,
  input wire pilot_indicator,
  input wire manual_indicator,
  input wire direction_inversion_indicator
);
  localparam int S = MS_CYCLES;
  int c1, cb, h1, hb, quiet;
  wire [3:0] act = {factory_reset_req, restart_req, manual_teach_start,
    auto_teach_start};
  default clocking dck @(posedge sys_clk); endclocking
  default disable iff (reset);

  // Raw hold lengths; a 10 cycle margin absorbs sync and debounce
  always @(posedge sys_clk or posedge reset) begin
    if (reset) begin
      c1 <= 0;
      cb <= 0;
      h1 <= 0;
      hb <= 0;
      quiet <= 0;
    end else begin
      c1 <= key_one ? c1 + 1 : 0;
      cb <= (key_one && key_two) ? cb + 1 : 0;
      if (!key_one && c1 != 0)
        h1 <= c1;
      if (!(key_one && key_two) && cb != 0)
        hb <= cb;
      quiet <= (key_one || key_two || wr_en) ? 0 :
        (quiet < 20 ? quiet + 1 : 20);
    end
  end

  AST_AUTO_WINDOW: assert property (
    auto_teach_start |-> h1 > 5000*S-10 && h1 <= 10000*S+10)
    else $error("auto teach outside its hold window");
  AST_MANUAL_WINDOW: assert property (
    manual_teach_start |-> h1 > 10000*S-10)
    else $error("manual teach after too short a hold");
  AST_RESTART_WINDOW: assert property (
    restart_req |-> hb > 10000*S-10 && hb <= 30000*S+10)
    else $error("restart outside its hold window");
  AST_FACTORY_WINDOW: assert property (
    factory_reset_req |-> hb > 30000*S-10)
    else $error("factory reset after too short a hold");
  AST_SINGLE_PULSE: assert property (
    |act |-> $onehot(act) ##1 act == 4'h0)
    else $error("action pulse not single");
  AST_AFTER_RELEASE: assert property (
    |act |-> !key_one && !key_two && $past(!key_one && !key_two))
    else $error("action pulse while a key is down");
  AST_STEADY_IDLE: assert property (
    quiet == 20 |-> $stable(manual_indicator)
      && $stable(direction_inversion_indicator))
    else $error("indicator moved while keys idle");
  AST_PILOT_SHOWN: assert property (
    quiet == 20 |-> pilot_indicator == pilot_valve)
    else $error("pilot indicator differs from pilot valve");
endmodule

bind key_panel key_panel_properties #(.MS_CYCLES(MS_CYCLES)) i_props (
  .sys_clk(sys_clk), .reset(reset), .key_one(key_one),
  .key_two(key_two), .wr_en(wr_en), .auto_teach_start(auto_teach_start),
  .manual_teach_start(manual_teach_start), .restart_req(restart_req),
  .factory_reset_req(factory_reset_req), .pilot_valve(pilot_valve),
  .pilot_indicator(pilot_indicator), .manual_indicator(manual_indicator),
  .direction_inversion_indicator(direction_inversion_indicator));

// >>> verification/key_panel_test.sv
`timescale 1ns/1ns
// Self-checking bench for the two-key panel
module key_panel_test;
  localparam int CLK = 1000;
  logic sys_clk = 0, reset = 1, wr_en = 0, rd_en = 0;
  logic [7:0] addr = 8'h00;
  logic [31:0] wdata = 32'h0, seed = 32'h12193449, r;
  logic [5:0] ins = 6'h00;
  wire [31:0] rdata;
  wire [2:0] status_rgb;
  wire key_one, key_two, auto_teach_start, manual_teach_start;
  wire restart_req, factory_reset_req, pilot_valve, pilot_indicator;
  wire manual_indicator, direction_inversion_indicator;
  wire bus_power_indicator, bus_fault_indicator;
  wire [5:0] leds = {bus_fault_indicator, bus_power_indicator,
    |status_rgb, pilot_indicator, direction_inversion_indicator,
    manual_indicator};
  int err_total = 0, cmp_count = 0;
  int hi [6], tg [6];
  logic [3:0] pc [4] = '{default:0};

  // Short ms and flash periods keep the long holds affordable
  key_panel #(.CLK_HZ(CLK), .MS_CYCLES(1), .DEBOUNCE_MS(2)) i_dut (
    .sys_clk(sys_clk), .reset(reset), .key_one(key_one),
    .key_two(key_two), .addr(addr), .wdata(wdata), .wr_en(wr_en),
    .rd_en(rd_en), .rdata(rdata), .valve_open(ins[0]),
    .valve_closed(ins[1]), .device_error(ins[2]),
    .function_check(ins[3]), .out_of_spec(ins[4]),
    .maint_required(ins[5]), .auto_teach_start(auto_teach_start),
    .manual_teach_start(manual_teach_start), .restart_req(restart_req),
    .factory_reset_req(factory_reset_req), .pilot_valve(pilot_valve),
    .pilot_indicator(pilot_indicator), .manual_indicator(manual_indicator),
    .direction_inversion_indicator(direction_inversion_indicator),
    .status_rgb(status_rgb), .bus_power_indicator(bus_power_indicator),
    .bus_fault_indicator(bus_fault_indicator));
  key_operator #(.MS_CYCLES(1)) op (
    .sys_clk(sys_clk), .key_one(key_one), .key_two(key_two));

  // 50 MHz clock
  always #10 sys_clk = ~sys_clk;

  // Count each action pulse
  always @(posedge sys_clk) begin
    pc[0] <= pc[0] + auto_teach_start;
    pc[1] <= pc[1] + manual_teach_start;
    pc[2] <= pc[2] + restart_req;
    pc[3] <= pc[3] + factory_reset_req;
  end

  task finish_test;
    $display("comparisons %0d mismatches %0d", cmp_count, err_total);
    if (err_total == 0 && cmp_count > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  endtask

  task chk(input string n, input logic [31:0] e, g);
    cmp_count++;
    if (g !== e) begin
      err_total++;
      $display("MISMATCH %s expected %h seen %h", n, e, g);
    end
  endtask

  function logic [31:0] xs();
    seed = seed ^ (seed << 13);
    seed = seed ^ (seed >> 17);
    seed = seed ^ (seed << 5);
    return seed;
  endfunction

  task wr(input [7:0] a, input [31:0] d);
    @(posedge sys_clk);
    wr_en <= 1;
    addr <= a;
    wdata <= d;
    @(posedge sys_clk);
    wr_en <= 0;
  endtask

  // Read data stand only in the cycle after the strobe
  task rd(input [7:0] a, input [31:0] e, input string n);
    @(posedge sys_clk);
    rd_en <= 1;
    addr <= a;
    @(posedge sys_clk);
    rd_en <= 0;
    #1 chk(n, e, rdata);
  endtask

  // Tally level and toggles of every indicator over n cycles
  task watch(input int n);
    logic [5:0] p;
    hi = '{default:0};
    tg = '{default:0};
    p = leds;
    repeat (n) begin
      @(posedge sys_clk);
      #1;
      for (int i = 0; i < 6; i++) begin
        hi[i] += leds[i];
        tg[i] += leds[i] != p[i];
      end
      p = leds;
    end
  endtask

  // 0 dark, 1 lit, 2 slow flash, 3 fast flash
  function logic [1:0] cls(input int i, n);
    if (tg[i] == 0)
      return hi[i] != 0 ? 2'd1 : 2'd0;
    return tg[i] * CLK > 15 * n ? 2'd3 : 2'd2;
  endfunction

  function logic [5:0] cl3();
    return {cls(2, 800), cls(1, 800), cls(0, 800)};
  endfunction

  // Hold keys, classify indicators in two windows, then count pulses
  task key_test(input [1:0] m, input int ms, a, b,
    input [5:0] ea, eb, input [15:0] ep);
    #1 pc = '{default:0};
    fork
      op.hold(m, ms);
      if (a >= 0) begin
        repeat (a + 8) @(posedge sys_clk);
        watch(800);
        chk("leds_early", ea, cl3());
        repeat (b - a - 800) @(posedge sys_clk);
        watch(800);
        chk("leds_late", eb, cl3());
      end
    join
    repeat (30) @(posedge sys_clk);
    chk("pulses", ep, {pc[3], pc[2], pc[1], pc[0]});
  endtask

  // Main sequence
  initial begin
    logic [3:0] bx [6];
    bx = '{4'h0, 4'h1, 4'h5, 4'h6, 4'h9, 4'ha};
    repeat (16) @(posedge sys_clk);
    reset <= 0;
    rd(8'h00, 32'h0, "ctrl");
    rd(8'h04, 32'h1, "status");
    rd(8'h0c, 32'h0, "bus");
    rd(8'h08, 32'h2, "mode");
    wr(8'h10, 32'hffffffff);
    rd(8'h10, 32'h0, "unmapped");
    for (int k = 0; k < 7; k++) begin
      wr(8'h08, k);
      rd(8'h08, k < 6 ? k : 5, "mode");
      // No valve position, no device status: only the priority and
      // fixed colour modes light the status indicator
      chk("status", k == 3 ? 2 : k == 4 ? 7 : 0, status_rgb);
    end
    wr(8'h08, 32'h2);
    for (int k = 0; k < 6; k++) begin
      wr(8'h0c, k);
      // Let the pair settle, else the level change counts as a toggle
      repeat (2) @(posedge sys_clk);
      watch(800);
      chk("bus_pair", bx[k], {cls(5, 800) > 1 ? 2'd2 : cls(5, 800),
        cls(4, 800) > 1 ? 2'd2 : cls(4, 800)});
    end
    chk("status_auto", 2'd0, cls(3, 800));
    for (int k = 0; k < 8; k++) begin
      r = xs();
      ins <= r[9:4];
      wr(8'h00, r & 32'hf);
      rd(8'h00, r & 32'hf, "ctrl");
      repeat (25) @(posedge sys_clk);
      #1 chk("steady", {r[3], r[3], r[2], r[1]}, {pilot_valve,
        pilot_indicator, direction_inversion_indicator,
        manual_indicator});
    end
    ins <= 6'h00;
    wr(8'h00, 32'h1);
    key_test(2'b11, 3000, 100, 2000, 6'h00, 6'h00, 16'h0);
    rd(8'h00, 32'h1, "ctrl");
    wr(8'h00, 32'h0);
    key_test(2'b10, 100, -1, 0, 6'h0, 6'h0, 16'h0);
    rd(8'h00, 32'h0, "ctrl");
    key_test(2'b11, 5000, 100, 3000, 6'h02, 6'h03, 16'h0);
    rd(8'h00, 32'h2, "ctrl");
    watch(800);
    chk("hand_leds", 4'h9, {cls(3, 800), cls(0, 800)});
    key_test(2'b10, 100, -1, 0, 6'h0, 6'h0, 16'h0);
    rd(8'h00, 32'ha, "ctrl");
    key_test(2'b10, 12000, 1000, 10500, 6'h19, 6'h1d, 16'h0);
    rd(8'h00, 32'he, "ctrl");
    key_test(2'b01, 7000, 500, 5500, 6'h1a, 6'h1f, 16'h1);
    key_test(2'b01, 11000, 2000, 10100, 6'h1a, 6'h1a, 16'h10);
    key_test(2'b11, 15000, 3000, 11000, 6'h17, 6'h2a, 16'h100);
    key_test(2'b11, 31000, 12000, 30100, 6'h2a, 6'h3f, 16'h1000);
    finish_test;
  end

  // Cut a hang short
  initial begin
    repeat (120000) @(posedge sys_clk);
    err_total++;
    finish_test;
  end
endmodule
